// file: hw/sie_pkg.sv
// constants shared by the safety interlock evaluator
package sie_pkg;
    // clock rate in MHz
    localparam int CLK_MHZ = 10;
    // actuator polling period, microseconds
    localparam int POLL_PERIOD_US = 1000;
    localparam int POLL_CYC = POLL_PERIOD_US * CLK_MHZ;
    // longest relay travel before readback must agree, milliseconds
    localparam int RELAY_SETTLE_MS = 20;
    localparam int RELAY_SETTLE_CYC = RELAY_SETTLE_MS * 1000 * CLK_MHZ;
    // byte offsets of the registers
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_TEACH_CNT = 6'h08;
    localparam logic [5:0] OFS_SWITCH_CNT = 6'h0C;
    // control fields
    localparam int CTRL_FB_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_LOCK_LSB = 4;
    localparam int CTRL_ACT_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h00000F00;
    // status fields
    localparam int ST_MATCH_LSB = 0;
    localparam int ST_PRESENT_LSB = 4;
    localparam int ST_LOCKED_LSB = 8;
    localparam int ST_TAUGHT_LSB = 12;
    localparam int ST_RELAY_BIT = 16;
    localparam int ST_FAULT_BIT = 17;
    localparam int ST_FB_BIT = 18;
    // width of the operation totals
    localparam int CNT_W = 32;
    // evaluator states
    typedef enum logic [1:0] {SIE_OFF, SIE_ON, SIE_FAULT} sie_state_t;
endpackage

// file: hw/sie_evaluator.sv
// evaluation logic of the non-contact guard interlock
//
// Summary of operation
// - relays off whenever a guard opens
// - locking head: relays off on lock release
// - locked reported only with actuator present
// - one, two or four head channels
// - start request on start falling edge
// - teach-in stores expected code per channel
// - read code only once actuator present
// - compare read code with taught code
// - code match drives door output low
// - relays need all active matches; lamp lit
// - feedback option: start needs closed loop
// - welded contactor blocks next start
// - safe state on every detected fault
// - lamp off when relays drop
// - relay state checked by readback contacts
// - door outputs independent of relay state
// - fault: relays off, diag high, red
// - count teach-ins and switchings
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sie_evaluator #(
    parameter int NUM_HEADS = 4,
    parameter int CODE_W = 16,
    parameter int POLL_CYC = sie_pkg::POLL_CYC,
    parameter int SETTLE_CYC = sie_pkg::RELAY_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // read head front ends, asynchronous pins
    input wire logic [NUM_HEADS-1:0] head_present,
    input wire logic [NUM_HEADS-1:0] head_code_valid,
    input wire logic [NUM_HEADS*CODE_W-1:0] head_code,
    input wire logic [NUM_HEADS-1:0] head_locked,
    output logic [NUM_HEADS-1:0] head_poll,
    // machine side pins, asynchronous
    input wire logic start_n,
    input wire logic feedback_closed,
    input wire logic teach_jumper,
    input wire logic relay_nc_a,
    input wire logic relay_nc_b,
    // open-drain door outputs: level and enable
    output logic [NUM_HEADS-1:0] door_state_output,
    output logic [NUM_HEADS-1:0] door_state_oe,
    // redundant relay drives and indicators
    output logic relay_a,
    output logic relay_b,
    output logic enable_lamp,
    output logic fault_indicator_output,
    output logic fault_lamp_red
);
    localparam int N = NUM_HEADS;
    // timers are wide enough for the default relay settle time
    localparam int TW = 24;
    localparam logic [TW-1:0] POLL_LAST = TW'(POLL_CYC - 1);
    localparam logic [TW-1:0] SETTLE_LAST = TW'(SETTLE_CYC - 1);

    // whole state of the block
    typedef struct packed {
        logic [N-1:0] pres_s1, pres_s2; // actuator in range
        logic [N-1:0] val_s1, val_s2; // code word valid
        logic [N-1:0] lck_s1, lck_s2; // locking bolt engaged
        logic [N-1:0][CODE_W-1:0] code_s1, code_s2;
        logic [1:0] start_s, fb_s, nca_s, ncb_s, jmp_s;
        logic start_prev, jmp_prev;
        logic [N-1:0][CODE_W-1:0] taught; // expected codes
        logic [N-1:0] taught_ok;
        logic [N-1:0][CODE_W-1:0] last_code; // latest read
        logic [N-1:0] fresh; // code seen this period
        logic [N-1:0] seen; // code seen last period
        logic [TW-1:0] poll_cnt;
        logic [N-1:0] poll;
        logic [TW-1:0] settle_cnt;
        sie_pkg::sie_state_t state; // enable sequencing
        logic relay_a, relay_b, lamp, diag, red;
        logic [N-1:0] door_oe;
        logic [31:0] ctrl;
        logic [sie_pkg::CNT_W-1:0] teach_cnt, switch_cnt;
        logic ack, wait_r;
        logic [31:0] rdata;
    } sie_st_t;

    sie_st_t q_ff, nxt_q;

    // per channel evaluation, shared by the update and the checks
    logic [N-1:0] active, lock_mask, code_eq, match_raw, match;
    logic [N-1:0] lock_ok, ch_ok;
    logic all_ok, fb_ok, start_fall, start_ok, disagree;

    // merge a bus write into a word under its byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        // lanes that are not enabled keep their old byte
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign active = q_ff.ctrl[sie_pkg::CTRL_ACT_LSB +: N];
    assign lock_mask = q_ff.ctrl[sie_pkg::CTRL_LOCK_LSB +: N];

    // channel checks; only the second sync stage is read
    always_comb begin
        for (int i = 0; i < N; i++) begin
            code_eq[i] = q_ff.last_code[i] == q_ff.taught[i];
            // a stale read does not count: polling must stay alive
            match_raw[i] = q_ff.pres_s2[i] & q_ff.seen[i]
                & q_ff.taught_ok[i] & code_eq[i];
            // bolt counts only with the actuator inside
            lock_ok[i] = ~lock_mask[i]
                | (q_ff.lck_s2[i] & q_ff.pres_s2[i]);
        end
    end
    assign match = match_raw & active;
    assign ch_ok = ~active | (match & lock_ok);
    assign all_ok = (&ch_ok) & (|active);
    assign fb_ok = ~q_ff.ctrl[sie_pkg::CTRL_FB_BIT]
        | q_ff.fb_s[1];
    assign start_fall = q_ff.start_prev & ~q_ff.start_s[1];
    assign start_ok = ~q_ff.ctrl[sie_pkg::CTRL_START_BIT] | start_fall;
    // closed readback contact while the relay is driven, or open
    // while released, is a stuck or welded relay
    assign disagree = (q_ff.nca_s[1] == q_ff.relay_a)
        | (q_ff.ncb_s[1] == q_ff.relay_b);

    // next state
    always_comb begin
        nxt_q = q_ff;
        // two-stage synchronisers on every pin
        // the first stage may go metastable, so only stage two is used
        nxt_q.pres_s1 = head_present;
        nxt_q.pres_s2 = q_ff.pres_s1;
        nxt_q.val_s1 = head_code_valid;
        nxt_q.val_s2 = q_ff.val_s1;
        nxt_q.lck_s1 = head_locked;
        nxt_q.lck_s2 = q_ff.lck_s1;
        nxt_q.code_s1 = head_code;
        nxt_q.code_s2 = q_ff.code_s1;
        nxt_q.start_s = {q_ff.start_s[0], start_n};
        nxt_q.fb_s = {q_ff.fb_s[0], feedback_closed};
        nxt_q.nca_s = {q_ff.nca_s[0], relay_nc_a};
        nxt_q.ncb_s = {q_ff.ncb_s[0], relay_nc_b};
        nxt_q.jmp_s = {q_ff.jmp_s[0], teach_jumper};
        nxt_q.start_prev = q_ff.start_s[1];
        nxt_q.jmp_prev = q_ff.jmp_s[1];

        // code capture, only from an actuator in range
        for (int i = 0; i < N; i++) begin
            if (q_ff.val_s2[i] && q_ff.pres_s2[i]) begin
                nxt_q.last_code[i] = q_ff.code_s2[i];
                nxt_q.fresh[i] = 1'b1;
            end
        end

        // dynamic polling: a head that stops answering reads as open
        nxt_q.poll = '0;
        if (q_ff.poll_cnt == POLL_LAST) begin
            nxt_q.poll_cnt = '0;
            nxt_q.poll = {N{1'b1}};
            // a capture in the tick cycle is not lost
            nxt_q.seen = q_ff.fresh | (q_ff.val_s2 & q_ff.pres_s2);
            nxt_q.fresh = q_ff.val_s2 & q_ff.pres_s2;
        end else begin
            nxt_q.poll_cnt = q_ff.poll_cnt + 1'b1;
        end

        // teach-in while the jumper is set
        if (q_ff.jmp_s[1]) begin
            for (int i = 0; i < N; i++) begin
                if (q_ff.val_s2[i] && q_ff.pres_s2[i]) begin
                    nxt_q.taught[i] = q_ff.code_s2[i];
                    nxt_q.taught_ok[i] = 1'b1;
                end
            end
        end
        if (q_ff.jmp_s[1] && !q_ff.jmp_prev) begin
            nxt_q.teach_cnt = q_ff.teach_cnt + 1'b1;
        end

        // door outputs follow the doors, not the relays
        nxt_q.door_oe = match_raw;

        // relay readback supervision
        // a stuck relay is only caught once the settle time runs out
        if (disagree && q_ff.state != sie_pkg::SIE_FAULT) begin
            nxt_q.settle_cnt = q_ff.settle_cnt + 1'b1;
        end else begin
            nxt_q.settle_cnt = '0;
        end

        // enable sequencing
        unique case (q_ff.state)
            sie_pkg::SIE_OFF: begin
                // no start while teaching or with an open loop
                if (all_ok && fb_ok && start_ok && !q_ff.jmp_s[1]) begin
                    nxt_q.state = sie_pkg::SIE_ON;
                    nxt_q.relay_a = 1'b1;
                    nxt_q.relay_b = 1'b1;
                    nxt_q.lamp = 1'b1;
                    nxt_q.switch_cnt = q_ff.switch_cnt + 1'b1;
                end
            end
            sie_pkg::SIE_ON: begin
                if (!all_ok || q_ff.jmp_s[1]) begin
                    nxt_q.state = sie_pkg::SIE_OFF;
                    nxt_q.relay_a = 1'b0;
                    nxt_q.relay_b = 1'b0;
                    nxt_q.lamp = 1'b0;
                end
            end
            sie_pkg::SIE_FAULT: begin
                // held until reset, nothing leaves it
                nxt_q.state = sie_pkg::SIE_FAULT;
            end
            default: begin
                // an illegal state code is treated as a fault
                nxt_q.state = sie_pkg::SIE_FAULT;
            end
        endcase

        // fault overrides everything above
        // placed last so that no branch above can re-enable a relay
        if (q_ff.settle_cnt == SETTLE_LAST
                || q_ff.relay_a != q_ff.relay_b) begin
            nxt_q.state = sie_pkg::SIE_FAULT;
        end
        if (nxt_q.state == sie_pkg::SIE_FAULT) begin
            nxt_q.relay_a = 1'b0;
            nxt_q.relay_b = 1'b0;
            nxt_q.lamp = 1'b0;
            nxt_q.diag = 1'b1;
            nxt_q.red = 1'b1;
        end

        // bus slave: one wait state, then the answer
        // a fixed wait state keeps the register decode off the bus path
        nxt_q.ack = 1'b0;
        if ((read || write) && !q_ff.ack) begin
            nxt_q.ack = 1'b1;
            unique case (address)
                sie_pkg::OFS_CTRL: nxt_q.rdata = q_ff.ctrl;
                sie_pkg::OFS_STATUS: begin
                    nxt_q.rdata = '0;
                    nxt_q.rdata[sie_pkg::ST_MATCH_LSB +: N] = match;
                    nxt_q.rdata[sie_pkg::ST_PRESENT_LSB +: N] =
                        q_ff.pres_s2;
                    nxt_q.rdata[sie_pkg::ST_LOCKED_LSB +: N] =
                        q_ff.lck_s2 & q_ff.pres_s2;
                    nxt_q.rdata[sie_pkg::ST_TAUGHT_LSB +: N] =
                        q_ff.taught_ok;
                    nxt_q.rdata[sie_pkg::ST_RELAY_BIT] = q_ff.relay_a;
                    nxt_q.rdata[sie_pkg::ST_FAULT_BIT] = q_ff.diag;
                    nxt_q.rdata[sie_pkg::ST_FB_BIT] = q_ff.fb_s[1];
                end
                sie_pkg::OFS_TEACH_CNT: nxt_q.rdata = q_ff.teach_cnt;
                sie_pkg::OFS_SWITCH_CNT: nxt_q.rdata = q_ff.switch_cnt;
                default: nxt_q.rdata = '0; // unmapped reads zero
            endcase
        end
        // write lands at the edge that sees waitrequest low
        if (q_ff.ack && write && address == sie_pkg::OFS_CTRL) begin
            nxt_q.ctrl = be_merge(q_ff.ctrl, writedata, byteenable);
        end
        nxt_q.wait_r = ~nxt_q.ack;
    end

    // state register; reset clears the totals along with the rest
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.state <= sie_pkg::SIE_OFF;
            q_ff.ctrl <= sie_pkg::CTRL_RST;
            q_ff.wait_r <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from the state register
    assign readdata = q_ff.rdata;
    assign waitrequest = q_ff.wait_r;
    assign head_poll = q_ff.poll;
    // open-drain: only ever pulls low, enable carries the state
    assign door_state_output = '0;
    assign door_state_oe = q_ff.door_oe;
    assign relay_a = q_ff.relay_a;
    assign relay_b = q_ff.relay_b;
    assign enable_lamp = q_ff.lamp;
    assign fault_indicator_output = q_ff.diag;
    assign fault_lamp_red = q_ff.red;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    open_drop_a: assert property (
        q_ff.state == sie_pkg::SIE_ON && !all_ok
        |=> !q_ff.relay_a && !q_ff.relay_b)
        else $error("relays stayed on with a guard open");
    lock_drop_a: assert property (
        q_ff.relay_a && |(active & lock_mask & ~q_ff.lck_s2)
        |=> !q_ff.relay_a)
        else $error("relays stayed on with locking released");
    // a guard may open while the relays still drop, so the bolt is
    // judged only in the cycle before the relays rise
    lock_present_a: assert property (
        $rose(q_ff.relay_a) |-> $past(&(~(active & lock_mask)
            | (q_ff.lck_s2 & q_ff.pres_s2))))
        else $error("locked reported without actuator");
    start_edge_a: assert property (
        $rose(q_ff.relay_a) && q_ff.ctrl[sie_pkg::CTRL_START_BIT]
        |-> $past(start_fall))
        else $error("start without falling edge");
    relay_match_a: assert property (
        $rose(q_ff.relay_a) |-> $past(all_ok) && q_ff.lamp)
        else $error("enable without full match");
    fb_block_a: assert property (
        $rose(q_ff.relay_a) && q_ff.ctrl[sie_pkg::CTRL_FB_BIT]
        |-> $past(q_ff.fb_s[1]))
        else $error("start with feedback loop open");
    lamp_off_a: assert property (
        $fell(q_ff.relay_a) |-> !q_ff.lamp)
        else $error("lamp lit with relays off");
    readback_a: assert property (
        q_ff.settle_cnt == SETTLE_LAST
        |=> q_ff.state == sie_pkg::SIE_FAULT ##1 q_ff.diag)
        else $error("readback mismatch not faulted");
    fault_hold_a: assert property (
        q_ff.state == sie_pkg::SIE_FAULT |=> q_ff.state
        == sie_pkg::SIE_FAULT && !q_ff.relay_a && q_ff.diag)
        else $error("fault state left or outputs on");
    teach_a: assert property (
        q_ff.jmp_s[1] && q_ff.val_s2[0] && q_ff.pres_s2[0]
        |=> q_ff.taught[0] == $past(q_ff.code_s2[0]))
        else $error("teach-in did not store code");
    switch_cnt_a: assert property (
        $rose(q_ff.relay_a)
        |-> q_ff.switch_cnt == $past(q_ff.switch_cnt) + 1'b1)
        else $error("switching operation not counted");
    fault_out_a: assert property (
        q_ff.state == sie_pkg::SIE_FAULT |-> !q_ff.relay_a
        && !q_ff.relay_b && !q_ff.lamp && q_ff.diag && q_ff.red)
        else $error("fault outputs wrong");
    door_indep_a: assert property (
        q_ff.state == sie_pkg::SIE_FAULT && match_raw[0]
        |=> q_ff.door_oe[0])
        else $error("door output lost in fault");
    door_taught_a: assert property (
        q_ff.door_oe[0] |-> q_ff.taught_ok[0])
        else $error("door matched without taught code");

    start_c: cover property ($rose(q_ff.relay_a));
    open_c: cover property ($fell(q_ff.relay_a) && !q_ff.diag);
    fault_c: cover property ($rose(q_ff.diag));
    teach_c: cover property ($rose(q_ff.teach_cnt[0]));
    unlock_c: cover property ($fell(q_ff.relay_a)
        && |(lock_mask & ~q_ff.lck_s2));
endmodule

// file: dv/sie_head_model.sv
// behavioural read heads with coded actuators
`timescale 1ns/1ns
module sie_head_model #(
    parameter int N = 4,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic [N-1:0] closed,
    input wire logic [N-1:0] bolt,
    input wire logic [N*W-1:0] code,
    input wire logic slow,
    input wire logic [N-1:0] head_poll,
    output logic [N-1:0] head_present,
    output logic [N-1:0] head_code_valid,
    output logic [N*W-1:0] head_code,
    output logic [N-1:0] head_locked
);
    // scrambles the code lines while no word is valid
    logic [W-1:0] junk = '0;
    // cycles left of a slow answer, per head
    logic [2:0] left [N] = '{default: 3'h0};
    // pins start quiet
    initial begin
        head_present = '0;
        head_code_valid = '0;
        head_code = '0;
        head_locked = '0;
    end
    // one update per clock, all heads alike
    always @(posedge clk) begin
        logic v;
        junk <= junk + 1'b1;
        for (int i = 0; i < N; i++) begin
            // actuator powered only inside switch-on distance
            head_present[i] <= closed[i];
            // bolt is driven by outside control, reported raw
            head_locked[i] <= bolt[i];
            if (head_poll[i]) begin
                left[i] <= 3'h4;
            end else if (left[i] != 3'h0) begin
                left[i] <= left[i] - 3'h1;
            end
            // slow heads answer only a few cycles after a poll
            v = closed[i] & head_present[i] & (!slow | left[i] != 3'h0);
            head_code_valid[i] <= v;
            // invalid code lines never keep the last word
            head_code[i*W +: W] <= v ? code[i*W +: W] : ~code[i*W +: W] ^ junk;
        end
    end
endmodule

// file: dv/safety_interlock_evaluator_bench.sv
// self-checking bench of the safety interlock evaluator
`timescale 1ns/1ns
`define CHK(g, e) chk(32'(g), 32'(e))
module safety_interlock_evaluator_bench;
    localparam int N = 4;
    localparam int W = 16;
    localparam int POLL = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    // avalon master side
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest;
    // head pins, from the partner model
    logic [N-1:0] head_present, head_code_valid, head_locked, head_poll;
    logic [N*W-1:0] head_code;
    // machine pins; start button idles released
    logic start_n = 1'b1;
    logic feedback_closed = 1'b1;
    logic teach_jumper = 1'b0;
    logic relay_nc_a, relay_nc_b, relay_a, relay_b, enable_lamp;
    logic fault_indicator_output, fault_lamp_red;
    logic [N-1:0] door_state_output, door_state_oe;
    // scene and reference model state
    logic [N-1:0] closed = '0;
    logic [N-1:0] bolt = '0;
    logic [N*W-1:0] code = '0;
    logic slow = 1'b0;
    logic weld = 1'b0;
    logic [2:0] rl_dly = 3'h0;
    logic [3:0] act = 4'hF;
    logic [3:0] lockm = 4'h0;
    bit start_opt, fb_opt, started, fault_m;
    int taught[$];
    int n_fail, samples_checked;
    logic [31:0] rng = 32'hC397;
    sie_evaluator #(.NUM_HEADS(N), .CODE_W(W), .POLL_CYC(POLL),
        .SETTLE_CYC(10)) u_dut (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .head_present(head_present),
        .head_code_valid(head_code_valid), .head_code(head_code),
        .head_locked(head_locked), .head_poll(head_poll),
        .start_n(start_n), .feedback_closed(feedback_closed),
        .teach_jumper(teach_jumper), .relay_nc_a(relay_nc_a),
        .relay_nc_b(relay_nc_b), .door_state_output(door_state_output),
        .door_state_oe(door_state_oe), .relay_a(relay_a),
        .relay_b(relay_b), .enable_lamp(enable_lamp),
        .fault_indicator_output(fault_indicator_output),
        .fault_lamp_red(fault_lamp_red));
    sie_head_model #(.N(N), .W(W)) u_heads (.clk(clk), .closed(closed),
        .bolt(bolt), .code(code), .slow(slow), .head_poll(head_poll),
        .head_present(head_present), .head_code_valid(head_code_valid),
        .head_code(head_code), .head_locked(head_locked));
    // contactor: readback opens three cycles after both drives
    always @(posedge clk) rl_dly <= {rl_dly[1:0], relay_a & relay_b};
    // a welded contact keeps channel a closed
    assign relay_nc_a = weld | ~rl_dly[2];
    assign relay_nc_b = ~rl_dly[2];
    initial begin
        forever #50 clk = ~clk;
    end
    // fixed-seed xorshift source of actuator codes
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // a door matches when closed and its taught code agrees
    function automatic logic [N-1:0] exp_oe();
        logic [N-1:0] e;
        e = '0;
        for (int i = 0; i < taught.size(); i++)
            e[i] = closed[i] && code[i*W +: W] == W'(taught[i]);
        return e;
    endfunction
    // relays need every active match, locks and the options met
    function automatic logic exp_rl();
        logic ok;
        logic [N-1:0] oe;
        oe = exp_oe();
        ok = taught.size() == N && !fault_m && !teach_jumper;
        ok &= (!start_opt || started) && (!fb_opt || feedback_closed);
        for (int i = 0; i < N; i++)
            ok &= (!act[i] || oe[i]) && (!lockm[i] || bolt[i] && closed[i]);
        return ok;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one avalon access; held until waitrequest is seen low
    task automatic bus(input bit wr, input logic [5:0] a,
            input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        // waitrequest is read at the rising edge, before it updates
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 50) begin
            n_fail++;
            conclude();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // two poll periods let a door settle, then all outputs agree
    task automatic settle(input string name);
        int k;
        repeat (2 * POLL + 8) @(negedge clk);
        for (k = 0; k < 60; k++) begin
            if (door_state_oe === exp_oe() && relay_a === exp_rl()) break;
            @(negedge clk);
        end
        `CHK(door_state_oe, exp_oe());
        `CHK(door_state_output, 4'h0);
        `CHK(relay_a, exp_rl());
        `CHK(relay_b, exp_rl());
        `CHK(enable_lamp, exp_rl());
        `CHK(fault_indicator_output, fault_m);
        `CHK(fault_lamp_red, fault_m);
        $display("test %s done", name);
        // hand back on a rising edge so the next stimulus lands there
        @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle("reset");
        bus(1'b0, sie_pkg::OFS_CTRL, 32'h0, 4'hF);
        `CHK(rd, 32'h00000F00);
        bus(1'b1, sie_pkg::OFS_TEACH_CNT, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, sie_pkg::OFS_TEACH_CNT, 32'h0, 4'hF);
        `CHK(rd, 32'h0);
        bus(1'b0, 6'h10, 32'h0, 4'hF);
        `CHK(rd, 32'h0);
        @(posedge clk);
        for (int i = 0; i < N; i++) code[i*W +: W] <= W'(xs());
        closed <= 4'hF;
        settle("untaught");
        teach_jumper <= 1'b1;
        repeat (2 * POLL + 8) @(posedge clk);
        teach_jumper <= 1'b0;
        for (int i = 0; i < N; i++) taught.push_back(int'(code[i*W +: W]));
        settle("taught");
        bus(1'b0, sie_pkg::OFS_TEACH_CNT, 32'h0, 4'hF);
        `CHK(rd, 32'h1);
        bus(1'b0, sie_pkg::OFS_SWITCH_CNT, 32'h0, 4'hF);
        `CHK(rd != 32'h0, 1'b1);
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000A03, 4'h1);
        bus(1'b0, sie_pkg::OFS_CTRL, 32'h0, 4'hF);
        `CHK(rd, 32'h00000F03);
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000F00, 4'hF);
        code[W +: W] <= code[W +: W] ^ 16'h0001;
        settle("wrong code");
        code[W +: W] <= code[W +: W] ^ 16'h0001;
        closed[2] <= 1'b0;
        settle("door open");
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000B00, 4'hF);
        act = 4'hB;
        settle("inactive head");
        closed[2] <= 1'b1;
        slow <= 1'b1;
        settle("slow heads");
        slow <= 1'b0;
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000F10, 4'hF);
        act = 4'hF;
        lockm = 4'h1;
        settle("lock released");
        bolt <= 4'h5;
        closed[2] <= 1'b0;
        // let the new bolt and door state pass the pin synchronisers
        repeat (4) @(posedge clk);
        bus(1'b0, sie_pkg::OFS_STATUS, 32'h0, 4'hF);
        `CHK(rd[11:8], 4'h1);
        closed[2] <= 1'b1;
        settle("locked");
        closed[0] <= 1'b0;
        feedback_closed <= 1'b0;
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000F01, 4'hF);
        lockm = 4'h0;
        fb_opt = 1'b1;
        closed[0] <= 1'b1;
        settle("feedback open");
        feedback_closed <= 1'b1;
        settle("feedback closed");
        closed[0] <= 1'b0;
        start_n <= 1'b0;
        bus(1'b1, sie_pkg::OFS_CTRL, 32'h00000F02, 4'hF);
        fb_opt = 1'b0;
        start_opt = 1'b1;
        closed[0] <= 1'b1;
        settle("start held");
        start_n <= 1'b1;
        settle("start rise");
        start_n <= 1'b0;
        started = 1'b1;
        settle("start fall");
        weld <= 1'b1;
        fault_m = 1'b1;
        settle("welded relay");
        weld <= 1'b0;
        settle("fault held");
        // only a reset leaves the fault; taught codes go with it
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        taught.delete();
        fault_m = 1'b0;
        start_opt = 1'b0;
        started = 1'b0;
        settle("reset again");
        bus(1'b0, sie_pkg::OFS_CTRL, 32'h0, 4'hF);
        `CHK(rd, 32'h00000F00);
        conclude();
    end
endmodule
